//--- src/sfr_pkg.sv
// Shared constants, types and helpers of the single-wire frame receiver
package sfr_pkg;

  // ****************************************
  // Register map and bus
  // ****************************************
  localparam int SFR_ADDR_W = 12;
  localparam int SFR_REG_W = 16;
  localparam logic [11:0] SFR_OFF_CTRL_ONE = 12'h000;
  localparam logic [11:0] SFR_OFF_CTRL_TWO = 12'h004;
  localparam logic [11:0] SFR_OFF_CTRL_THREE = 12'h008;
  localparam logic [11:0] SFR_OFF_SYNC_CAP = 12'h00C;
  localparam logic [11:0] SFR_OFF_DATA_HIGH = 12'h010;
  localparam logic [11:0] SFR_OFF_DATA_LOW = 12'h014;
  localparam logic [11:0] SFR_OFF_STATUS = 12'h018;
  localparam logic [15:0] SFR_CTRL_WMASK = 16'hAFD7;
  localparam logic [15:0] SFR_REG_RESET = 16'h0000;
  localparam int SFR_ST_DONE = 0;
  localparam int SFR_ST_CRC = 1;
  localparam int SFR_ST_FRM = 2;
  localparam int SFR_ST_BUSY = 3;

  // ****************************************
  // Frame timing in ticks
  // ****************************************
  localparam int SFR_SYNC_TICKS = 56;
  localparam int SFR_NIB_MIN_TICKS = 12;
  localparam int SFR_NIB_MAX_TICKS = 27;
  localparam int SFR_PAUSE_MAX_TICKS = 768;
  localparam logic [2:0] SFR_MAX_DATA_NIBS = 3'h6;
  localparam logic [2:0] SFR_MIN_DATA_NIBS = 3'h1;
  localparam logic [1:0] SFR_DIV_SLOW_LAST = 2'h3;

  // ****************************************
  // Checksum
  // ****************************************
  localparam logic [3:0] SFR_CRC_SEED = 4'h5;
  localparam logic [63:0] SFR_CRC_TABLE = 64'h582FB6C1493EA7D0;

  function automatic logic [3:0] sfr_crc_step(input logic [3:0] c, input logic [3:0] n);
    return SFR_CRC_TABLE[{c, 2'b00} +: 4] ^ n;
  endfunction : sfr_crc_step

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic module_on;
    logic rsv14;
    logic idle_halt;
    logic rsv12;
    logic receive_select;
    logic transmit_trigger_select;
    logic transmit_polarity;
    logic crc_check_on;
    logic pause_present;
    logic short_code_control_on;
    logic rsv5;
    logic clock_divider;
    logic rsv3;
    logic [2:0] nibble_count;
  } sfr_ctrl_t;

  typedef struct packed {
    logic ok;
    logic pause_ok;
    logic [3:0] value;
  } sfr_nib_t;

  typedef enum logic [1:0] {SFR_SEEK, SFR_NIB, SFR_PAUSE} sfr_state_t;

endpackage : sfr_pkg

//--- src/sfr_prescaler.sv
// Receive clock prescaler: count strobe at pclk or pclk/4
`timescale 1ns/100ps
module sfr_prescaler (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic div4,
  output logic tick
);
  import sfr_pkg::*;

  logic [1:0] cnt;
  logic [1:0] next_cnt;

  assign next_cnt = run ? cnt + 2'h1 : 2'h0;
  assign tick = run & (~div4 | (cnt == SFR_DIV_SLOW_LAST));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 2'h0;
    end else begin
      cnt <= next_cnt;
    end
  end

endmodule : sfr_prescaler

//--- src/sfr_nibble_decode.sv
// Interval to nibble decoder, scaled against the captured sync period
`timescale 1ns/100ps
module sfr_nibble_decode #(
  parameter int CNT_W = 16
) (
  input wire logic [CNT_W-1:0] interval,
  input wire logic [CNT_W-1:0] sync_ref,
  output sfr_pkg::sfr_nib_t res
);
  import sfr_pkg::*;

  localparam int W = CNT_W + 12;

  // Interval in half ticks times the sync length: interval*2*56 vs sync*(2t-1)
  function automatic logic [W-1:0] edge_at(input logic [CNT_W-1:0] s, input int t);
    return W'(s) * W'(2 * t - 1);
  endfunction : edge_at

  logic [W-1:0] scaled;
  logic [14:0] hit;
  logic [3:0] ones;
  logic nib_ok;
  logic pause_ok;

  assign scaled = W'(interval) * W'(2 * SFR_SYNC_TICKS);

  genvar j;
  generate
    for (j = 1; j <= 15; j++) begin : g_thr
      assign hit[j-1] = scaled >= edge_at(sync_ref, SFR_NIB_MIN_TICKS + j);
    end
  endgenerate

  always_comb begin
    ones = 4'h0;
    for (int k = 0; k < 15; k++) begin
      ones = ones + {3'h0, hit[k]};
    end
  end

  assign nib_ok = (scaled >= edge_at(sync_ref, SFR_NIB_MIN_TICKS)) &&
                  (scaled < edge_at(sync_ref, SFR_NIB_MAX_TICKS + 1));
  assign pause_ok = (scaled >= edge_at(sync_ref, SFR_NIB_MIN_TICKS)) &&
                    (scaled < edge_at(sync_ref, SFR_PAUSE_MAX_TICKS + 1));

  // Ticks minus twelve, 12..27 ticks valid
  assign res = '{ok: nib_ok, pause_ok: pause_ok, value: ones};

endmodule : sfr_nibble_decode

//--- src/sfr_receiver.sv
// Single-wire falling-edge frame receiver with APB register access
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
module sfr_receiver #(
  parameter int CNT_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sfr_pkg::SFR_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sent_rx,
  output logic frame_done_irq
);
  import sfr_pkg::*;

  if (CNT_W < SFR_REG_W || CNT_W > 20) begin : g_chk
    $error("sfr_receiver: CNT_W must lie in 16..20");
  end

  // ****************************************
  // Registers and state
  // ****************************************
  sfr_ctrl_t ctrl;
  logic [15:0] sync_high_limit;
  logic [15:0] sync_low_limit;
  logic [CNT_W-1:0] sync_cap;
  logic [31:0] frame_data;
  logic sts_done;
  logic sts_crc;
  logic sts_frm;
  sfr_state_t st;
  sfr_state_t next_st;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [2:0] nib_idx;
  logic [31:0] frame_buf;
  logic [3:0] crc_run;
  logic line_prev;

  // ****************************************
  // APB decode
  // ****************************************
  logic hit_c1;
  logic hit_c2;
  logic hit_c3;
  logic hit_sc;
  logic hit_dh;
  logic hit_dl;
  logic hit_st;
  logic addr_ok;
  logic wr_en;
  logic setup;
  logic [31:0] rd_mux;
  logic [31:0] sts_word;

  assign hit_c1 = paddr == SFR_OFF_CTRL_ONE;
  assign hit_c2 = paddr == SFR_OFF_CTRL_TWO;
  assign hit_c3 = paddr == SFR_OFF_CTRL_THREE;
  assign hit_sc = paddr == SFR_OFF_SYNC_CAP;
  assign hit_dh = paddr == SFR_OFF_DATA_HIGH;
  assign hit_dl = paddr == SFR_OFF_DATA_LOW;
  assign hit_st = paddr == SFR_OFF_STATUS;
  assign addr_ok = hit_c1 | hit_c2 | hit_c3 | hit_sc | hit_dh | hit_dl | hit_st;
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite & addr_ok;
  assign pready = 1'b1;

  assign sts_word = {28'h0, st != SFR_SEEK, sts_frm, sts_crc, sts_done};
  assign rd_mux = hit_c1 ? {16'h0000, ctrl} :
                  hit_c2 ? {16'h0000, sync_high_limit} :
                  hit_c3 ? {16'h0000, sync_low_limit} :
                  hit_sc ? 32'(sync_cap) :
                  hit_dh ? {16'h0000, frame_data[31:16]} :
                  hit_dl ? {16'h0000, frame_data[15:0]} :
                  hit_st ? sts_word : 32'h0000_0000;

  // Read data and error are settled in the setup cycle, answer has no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr <= ~addr_ok;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= sfr_ctrl_t'(SFR_REG_RESET);
      sync_high_limit <= SFR_REG_RESET;
      sync_low_limit <= SFR_REG_RESET;
    end else if (wr_en) begin
      if (hit_c1) ctrl <= sfr_ctrl_t'(pwdata[15:0] & SFR_CTRL_WMASK);
      if (hit_c2) sync_high_limit <= pwdata[15:0];
      if (hit_c3) sync_low_limit <= pwdata[15:0];
    end
  end

  // ****************************************
  // Line sampling and interval counter
  // ****************************************
  logic active;
  logic tick;
  logic fall;
  logic sat;

  // Transmit trigger and polarity bits are stored only
  assign active = ctrl.module_on & ctrl.receive_select;
  assign fall = active & line_prev & ~sent_rx;
  assign sat = &cnt;
  assign next_cnt = (!active || fall) ? '0 :
                    (tick && !sat) ? cnt + 1'b1 : cnt;

  sfr_prescaler u_presc (
    .pclk(pclk),
    .presetn(presetn),
    .run(active),
    .div4(ctrl.clock_divider),
    .tick(tick)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_prev <= 1'b1;
      cnt <= '0;
    end else begin
      line_prev <= sent_rx;
      cnt <= next_cnt;
    end
  end

  // ****************************************
  // Frame sequencing
  // ****************************************
  sfr_nib_t dec;
  logic sync_ok;
  logic [2:0] data_nibs;
  logic [2:0] nib_last;
  logic is_crc;
  logic [2:0] slot;
  logic nib_evt;
  logic crc_evt;
  logic crc_match;
  logic done_evt;
  logic crc_bad;
  logic frm_evt;
  logic sync_acc;

  // Tick length is sync/56; the decoder scales each interval by it
  sfr_nibble_decode #(.CNT_W(CNT_W)) u_dec (
    .interval(cnt),
    .sync_ref(sync_cap),
    .res(dec)
  );

  assign sync_ok = (cnt >= CNT_W'(sync_low_limit)) && (cnt <= CNT_W'(sync_high_limit));
  assign sync_acc = (st == SFR_SEEK) & fall & sync_ok;
  assign data_nibs = (ctrl.nibble_count == 3'h0) ? SFR_MIN_DATA_NIBS :
                     (ctrl.nibble_count > SFR_MAX_DATA_NIBS) ? SFR_MAX_DATA_NIBS :
                     ctrl.nibble_count;
  assign nib_last = data_nibs + 3'h1;
  assign is_crc = nib_idx == nib_last;
  assign slot = is_crc ? 3'h0 : 3'h7 - nib_idx;
  assign nib_evt = (st == SFR_NIB) & fall & dec.ok;
  assign crc_evt = nib_evt & is_crc;
  assign crc_match = sfr_crc_step(crc_run, 4'h0) == dec.value;
  assign done_evt = crc_evt & (~ctrl.crc_check_on | crc_match);
  assign crc_bad = crc_evt & ctrl.crc_check_on & ~crc_match;
  assign frm_evt = ((st == SFR_NIB) & fall & ~dec.ok) |
                   ((st == SFR_PAUSE) & fall & ~dec.pause_ok);

  always_comb begin
    next_st = st;
    unique case (st)
      SFR_SEEK: begin
        if (sync_acc) next_st = SFR_NIB;
      end
      SFR_NIB: begin
        if (fall && !dec.ok) begin
          next_st = SFR_SEEK;
        end else if (crc_evt) begin
          next_st = ctrl.pause_present ? SFR_PAUSE : SFR_SEEK;
        end
      end
      SFR_PAUSE: begin
        if (fall) next_st = SFR_SEEK;
      end
    endcase
    if (!active) next_st = SFR_SEEK;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= SFR_SEEK;
      nib_idx <= 3'h0;
    end else begin
      st <= next_st;
      if (sync_acc) nib_idx <= 3'h0;
      else if (nib_evt && !is_crc) nib_idx <= nib_idx + 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_cap <= '0;
      frame_buf <= 32'h0000_0000;
      crc_run <= SFR_CRC_SEED;
    end else if (sync_acc) begin
      sync_cap <= cnt;
      frame_buf <= 32'h0000_0000;
      crc_run <= SFR_CRC_SEED;
    end else if (nib_evt) begin
      frame_buf[{slot, 2'b00} +: 4] <= dec.value;
      if (nib_idx != 3'h0 && !is_crc) crc_run <= sfr_crc_step(crc_run, dec.value);
    end
  end

  // ****************************************
  // Results and status
  // ****************************************
  logic wr_st;

  assign wr_st = wr_en & hit_st;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_data <= 32'h0000_0000;
      frame_done_irq <= 1'b0;
      sts_done <= 1'b0;
      sts_crc <= 1'b0;
      sts_frm <= 1'b0;
    end else begin
      if (done_evt) frame_data <= {frame_buf[31:4], dec.value};
      frame_done_irq <= done_evt;
      sts_done <= done_evt | (sts_done & ~(wr_st & pwdata[SFR_ST_DONE]));
      sts_crc <= crc_bad | (sts_crc & ~(wr_st & pwdata[SFR_ST_CRC]));
      sts_frm <= frm_evt | (sts_frm & ~(wr_st & pwdata[SFR_ST_FRM]));
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_sync_taken;
    (st == SFR_SEEK) && fall && sync_ok;
  endsequence

  sequence s_bad_nibble;
    (st == SFR_NIB) && fall && !dec.ok;
  endsequence

  rx_off_idle_a: assert property (!ctrl.receive_select |=> st == SFR_SEEK)
    else $error("receiver left idle while receive select is low");

  sync_reject_a: assert property ((st == SFR_SEEK) && fall && !sync_ok |=> st == SFR_SEEK)
    else $error("frame started on out-of-limit interval");

  sync_capture_a: assert property (s_sync_taken |=> st == SFR_NIB && sync_cap == $past(cnt))
    else $error("sync interval not captured");

  bad_nibble_a: assert property (s_bad_nibble |=> st == SFR_SEEK && sts_frm)
    else $error("bad nibble width did not abort the frame");

  done_pulse_a: assert property (done_evt |=> frame_done_irq ##1 !frame_done_irq)
    else $error("frame done event not a one-cycle pulse");

  done_data_a: assert property (done_evt |=> frame_data[3:0] == $past(dec.value) && sts_done)
    else $error("data registers not loaded on frame end");

  crc_gate_a: assert property (crc_evt && ctrl.crc_check_on && !crc_match
                               |=> !frame_done_irq && sts_crc)
    else $error("bad checksum accepted");

  crc_off_a: assert property (crc_evt && !ctrl.crc_check_on |=> frame_done_irq)
    else $error("frame rejected with checksum check off");

  pause_path_a: assert property (crc_evt && active |=>
                                 st == ($past(ctrl.pause_present) ? SFR_PAUSE : SFR_SEEK))
    else $error("wrong state after checksum nibble");

  module_off_a: assert property (!ctrl.module_on |=> st == SFR_SEEK && cnt == '0)
    else $error("disabled module kept running");

  // Nibbles taken since the sync, counted apart from the slot index
  logic [3:0] nib_seen;
  logic [3:0] nib_want;

  assign nib_want = 4'h1 + ((ctrl.nibble_count == 3'h0) ? {1'b0, SFR_MIN_DATA_NIBS} :
                            (ctrl.nibble_count > SFR_MAX_DATA_NIBS) ? {1'b0, SFR_MAX_DATA_NIBS} :
                            {1'b0, ctrl.nibble_count});

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nib_seen <= 4'h0;
    end else if (sync_acc) begin
      nib_seen <= 4'h0;
    end else if (nib_evt) begin
      nib_seen <= nib_seen + 4'h1;
    end
  end

  nib_count_a: assert property (crc_evt |-> nib_seen == nib_want)
    else $error("checksum nibble at wrong position");

endmodule : sfr_receiver

//--- sim/sfr_sent_source.sv
// SENT transmitter model that drives the receiver line
`timescale 1ns/100ps
module sfr_sent_source #(
  parameter int TICK_CYC = 4
) (
  input wire logic pclk,
  output logic sent_line
);
  // *****
  // Line idles high
  // *****
  initial sent_line = 1'b1;

  // One interval, fall to fall: low four ticks, then high
  task automatic pulse(input int ticks);
    sent_line <= 1'b0;
    repeat (4 * TICK_CYC) @(posedge pclk);
    sent_line <= 1'b1;
    repeat ((ticks - 4) * TICK_CYC) @(posedge pclk);
  endtask : pulse

  // Bad, when not zero, replaces the first data nibble length
  task automatic frame(input int sync, input logic [3:0] st, input logic [23:0] d,
                       input int n, input logic [3:0] crc, input int pause, input int bad);
    pulse(sync);
    pulse(12 + st);
    for (int i = 0; i < n; i++) begin
      pulse((i == 0 && bad != 0) ? bad : 12 + int'(d[23 - 4 * i -: 4]));
    end
    pulse(12 + crc);
    if (pause != 0) begin
      pulse(pause);
    end
    // Closing fall, then a gap longer than any sync
    pulse(104);
  endtask : frame
endmodule : sfr_sent_source

//--- sim/tb_sfr_receiver.sv
// Self-checking bench of the frame receiver
`timescale 1ns/100ps
`define CHK(a, b) \
  begin \
    compares++; \
    if ((a) !== (b)) begin \
      num_errors++; \
      $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); \
    end \
  end
module tb_sfr_receiver;
  import sfr_pkg::*;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sent_line;
  logic frame_done_irq;
  int num_errors = 0;
  int compares = 0;
  int irqs = 0;
  int cyc = 0;
  logic [31:0] wexp = 32'h0;

  sfr_receiver u_sfr_receiver (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sent_rx(sent_line),
    .frame_done_irq(frame_done_irq));
  // Eight clocks a tick, so the divide-by-four mode still resolves each nibble
  sfr_sent_source #(.TICK_CYC(8)) u_sfr_sent_source (.pclk(pclk), .sent_line(sent_line));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // *****
  // Event count and hang guard
  // *****
  always @(posedge pclk) begin
    cyc++;
    if (frame_done_irq === 1'b1) irqs++;
    if (cyc == 80000) begin
      num_errors++;
      close_out();
    end
  end

  task automatic close_out();
    if (num_errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out

  // *****
  // APB access
  // *****
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [32:0] r);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [32:0] r;
    apb(1'b1, a, d, r);
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [32:0] x);
    logic [32:0] r;
    apb(1'b0, a, 32'h0, r);
    `CHK(r, x)
  endtask : rdc

  // Checksum step: multiply by x^4 modulo x^4+x^3+x^2+1
  function automatic logic [3:0] m16(input logic [3:0] c);
    logic [7:0] v;
    v = {c, 4'h0};
    for (int b = 7; b >= 4; b--) begin
      if (v[b]) v = v ^ (8'h1D << (b - 4));
    end
    return v[3:0];
  endfunction : m16

  // *****
  // One frame with its checks
  // *****
  task automatic go(input logic [15:0] ctl, input logic [3:0] st, input logic [23:0] d,
                    input int n, input logic [3:0] cx, input int sync, input int pause,
                    input int bad, input logic [3:0] xs, input logic upd);
    int i0;
    logic [3:0] c;
    i0 = irqs;
    c = 4'h5;
    for (int i = 0; i < n; i++) c = m16(c) ^ d[23 - 4 * i -: 4];
    c = m16(c) ^ cx;
    if (upd) begin
      wexp = {st, 28'h0};
      for (int i = 0; i < n; i++) wexp[27 - 4 * i -: 4] = d[23 - 4 * i -: 4];
      wexp[3:0] = c;
    end
    wr(SFR_OFF_CTRL_ONE, {16'h0, ctl & 16'h7FFF});
    wr(SFR_OFF_CTRL_ONE, {16'h0, ctl});
    u_sfr_sent_source.frame(sync, st, d, n, c, pause, bad);
    rdc(SFR_OFF_STATUS, {29'h0, xs});
    `CHK(irqs - i0, int'(xs[0]))
    rdc(SFR_OFF_DATA_HIGH, {17'h0, wexp[31:16]});
    rdc(SFR_OFF_DATA_LOW, {17'h0, wexp[15:0]});
    wr(SFR_OFF_STATUS, 32'h7);
  endtask : go

  initial begin
    logic [32:0] r;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 0; a < 7; a++) rdc(12'(a * 4), 33'h0);
    rdc(12'h01C, {1'b1, 32'h0});
    wr(SFR_OFF_CTRL_ONE, 32'hFFFF_FFFF);
    rdc(SFR_OFF_CTRL_ONE, {17'h0, 16'hAFD7});
    wr(SFR_OFF_SYNC_CAP, 32'hFFFF);
    rdc(SFR_OFF_SYNC_CAP, 33'h0);
    // Nominal sync 448 counts: limits at 1.2 and 0.8 of it
    wr(SFR_OFF_CTRL_TWO, 32'h219);
    wr(SFR_OFF_CTRL_THREE, 32'h166);
    rdc(SFR_OFF_CTRL_TWO, 33'h219);
    rdc(SFR_OFF_CTRL_THREE, 33'h166);
    go(16'h8906, 4'hA, 24'h3C0F75, 6, 4'h0, 56, 0, 0, 4'h1, 1'b1);
    apb(1'b0, SFR_OFF_SYNC_CAP, 32'h0, r);
    `CHK(r[15:0] inside {[16'h1BF:16'h1C0]}, 1'b1)
    rdc(SFR_OFF_STATUS, 33'h0);
    go(16'h8906, 4'h5, 24'h123456, 6, 4'h3, 56, 0, 0, 4'h2, 1'b0);
    go(16'h8806, 4'h5, 24'h123456, 6, 4'h3, 56, 0, 0, 4'h1, 1'b1);
    go(16'h8903, 4'h9, 24'hABC000, 3, 4'h0, 56, 0, 0, 4'h1, 1'b1);
    go(16'h8900, 4'h7, 24'h800000, 1, 4'h0, 56, 0, 0, 4'h1, 1'b1);
    go(16'h8907, 4'h2, 24'hFEDCBA, 6, 4'h0, 56, 0, 0, 4'h1, 1'b1);
    go(16'h8906, 4'h1, 24'h111111, 6, 4'h0, 56, 0, 40, 4'h4, 1'b0);
    go(16'h8906, 4'h1, 24'h111111, 6, 4'h0, 70, 0, 0, 4'h0, 1'b0);
    go(16'h8906, 4'h1, 24'h111111, 6, 4'h0, 40, 0, 0, 4'h0, 1'b0);
    go(16'h0906, 4'h1, 24'h111111, 6, 4'h0, 56, 0, 0, 4'h0, 1'b0);
    go(16'h8106, 4'h1, 24'h111111, 6, 4'h0, 56, 0, 0, 4'h0, 1'b0);
    go(16'h8F86, 4'h6, 24'h0F1E2D, 6, 4'h0, 56, 100, 0, 4'h1, 1'b1);
    go(16'h8906, 4'h3, 24'h987654, 6, 4'h0, 56, 0, 0, 4'h1, 1'b1);
    // Divide-by-four: nominal sync 112 counts, limits at 1.2 and 0.8 of it
    wr(SFR_OFF_CTRL_TWO, 32'h86);
    wr(SFR_OFF_CTRL_THREE, 32'h59);
    go(16'h8916, 4'hC, 24'h5A0FF3, 6, 4'h0, 56, 0, 0, 4'h1, 1'b1);
    close_out();
  end
endmodule : tb_sfr_receiver
